// >>> hdl/fp_decoder_consts.vh
// constants for the floating-point instruction decoder
`ifndef FP_DECODER_CONSTS_VH
`define FP_DECODER_CONSTS_VH
`define OP_NONE            5'h00
`define OP_MUL_ACC         5'h01
`define OP_MUL_SUB         5'h02
`define OP_NEG_MUL_ACC     5'h03
`define OP_NEG_MUL_SUB     5'h04
`define OP_MULTIPLY        5'h05
`define OP_NEG_MULTIPLY    5'h06
`define OP_ADD             5'h07
`define OP_SUBTRACT        5'h08
`define OP_DIVIDE          5'h09
`define OP_MOVE_IMM        5'h0a
`define OP_MOVE_REG        5'h0b
`define OP_ABSOLUTE        5'h0c
`define OP_NEGATE          5'h0d
`define OP_SQUARE_ROOT     5'h0e
`define OP_HALF_CVT_BOTTOM 5'h0f
`define OP_HALF_CVT_TOP    5'h10
`define OP_COMPARE         5'h11
`define OP_COMPARE_SIGNAL  5'h12
`define OP_CVT_INT         5'h13
`define OP_CVT_FIXED       5'h14
`define OP_STORE_MULTIPLE  5'h15
`define OP_STORE_SINGLE    5'h16
`define OP_STACK_PUSH      5'h17
`define OP_LOAD_MULTIPLE   5'h18
`define OP_LOAD_SINGLE     5'h19
`define OP_STACK_POP       5'h1a
`define OP_XFER64          5'h1b
`define CLS_NONE           4'h0
`define CLS_DATA_OP        4'h1
`define CLS_LOAD           4'h2
`define CLS_STORE          4'h4
`define CLS_XFER64         4'h8
`define MODE_NONE          3'h0
`define MODE_INC_AFTER     3'h1
`define MODE_INC_AFTER_WB  3'h2
`define MODE_DEC_BEFORE_WB 3'h3
`define MODE_OFFSET        3'h4
`define STACK_REG          4'hd
`define CP_FP_SINGLE       4'ha
`define CP_FP_DOUBLE       4'hb
`define CP_FIELD_HI        11
`define CP_FIELD_LO        9
`define CP_FIELD_VAL       3'h5
`define WIDTH_BIT          8
`define T_BIT              28
`define DP_PREFIX          8'he
`define LS_PREFIX          7'h76
`define DP_PREFIX_VAL      8'hee
`define IMM_ZEROS          19
`endif

// >>> hdl/float_immediate_expander.v
// expands an eight-bit modified immediate into a single-precision constant
`timescale 1ns/1ps
`include "fp_decoder_consts.vh"
module float_immediate_expander (
  input  wire [7:0]  imm8,
  output wire [31:0] value
);
  // sign, inverted b, b five times, cdefgh, zero fill
  assign value = {imm8[7], ~imm8[6], {5{imm8[6]}}, imm8[5:0],
                  {`IMM_ZEROS{1'b0}}};
endmodule // float_immediate_expander

// >>> hdl/fp_instruction_decoder.v
// decoder for floating-point data-processing and load/store instructions
`timescale 1ns/1ps
`include "fp_decoder_consts.vh"
module fp_instruction_decoder (
  input  wire        core_clk,
  input  wire        reset,
  input  wire        clk_en,
  input  wire        insn_valid,
  input  wire [31:0] insn_word,
  output reg         dec_valid,
  output reg  [3:0]  dec_class,
  output reg  [4:0]  dec_op,
  output reg  [2:0]  dec_mode,
  output reg         dec_double,
  output reg  [4:0]  dest_reg,
  output reg  [4:0]  first_src_reg,
  output reg  [4:0]  second_src_reg,
  output reg  [3:0]  base_core_register,
  output reg  [7:0]  imm_offset,
  output reg  [31:0] imm_value,
  output reg  [3:0]  coproc_num,
  output reg         coproc_data_operation,
  output reg         coproc_load,
  output reg         coproc_store,
  output reg         undefined_insn
);
  // word layout: first halfword in [31:16], second in [15:0]
  wire        t_bit                  = insn_word[`T_BIT];
  wire        width_select_bit       = insn_word[`WIDTH_BIT];
  // table patterns read o3..o0 = bits 23..20, the 'x' position is bit 22
  wire [3:0]  primary_opcode_field   = insn_word[23:20];
  wire [3:0]  secondary_opcode_field = insn_word[19:16];
  wire [1:0]  tertiary_opcode_field  = insn_word[7:6];
  wire [3:0]  quaternary_opcode_field = insn_word[3:0];
  wire [4:0]  ls_opcode              = insn_word[24:20];
  wire [3:0]  dest_reg_field         = insn_word[15:12];
  wire [3:0]  first_src_reg_field    = insn_word[19:16];
  wire [3:0]  second_src_reg_field   = insn_word[3:0];
  wire        d_bit                  = insn_word[22];
  wire        n_bit                  = insn_word[7];
  wire        m_bit                  = insn_word[5];
  wire        cp_ok = insn_word[`CP_FIELD_HI:`CP_FIELD_LO] == `CP_FIELD_VAL;
  wire        dp_space = {insn_word[31:29], insn_word[27:24]} == 7'h7e &&
                         cp_ok && !insn_word[4];
  wire        ls_space = {insn_word[31:29], insn_word[27:25]} == 6'h3e &&
                         cp_ok;
  wire [31:0] exp_imm;

  float_immediate_expander u_expander (
    .imm8  ({secondary_opcode_field, quaternary_opcode_field}),
    .value (exp_imm)
  );

  reg [4:0] op_d;
  reg [3:0] class_d;
  reg [2:0] mode_d;
  reg       dbl_d;
  reg       undef_d;

  always @* begin
    op_d    = `OP_NONE;
    class_d = `CLS_NONE;
    mode_d  = `MODE_NONE;
    dbl_d   = 1'b0;
    undef_d = 1'b0;
    if (dp_space) begin
      class_d = `CLS_DATA_OP;
      if (t_bit || width_select_bit) begin
        undef_d = 1'b1;
      end else begin
        // unused register fields select the operation
        casez (primary_opcode_field)
          4'b0?00: op_d = tertiary_opcode_field[0] ? `OP_MUL_SUB
                                                   : `OP_MUL_ACC;
          4'b0?01: op_d = tertiary_opcode_field[0] ? `OP_NEG_MUL_SUB
                                                   : `OP_NEG_MUL_ACC;
          4'b0?10: op_d = tertiary_opcode_field[0] ? `OP_NEG_MULTIPLY
                                                   : `OP_MULTIPLY;
          4'b0?11: op_d = tertiary_opcode_field[0] ? `OP_SUBTRACT
                                                   : `OP_ADD;
          4'b1?00: op_d = tertiary_opcode_field[0] ? `OP_NONE
                                                   : `OP_DIVIDE;
          4'b1?11: begin
            if (!tertiary_opcode_field[0]) begin
              op_d = `OP_MOVE_IMM;
            end else begin
              casez ({secondary_opcode_field, tertiary_opcode_field[1]})
                5'b0000_0: op_d = `OP_MOVE_REG;
                5'b0000_1: op_d = `OP_ABSOLUTE;
                5'b0001_0: op_d = `OP_NEGATE;
                5'b0001_1: op_d = `OP_SQUARE_ROOT;
                5'b0010_?: op_d = `OP_HALF_CVT_BOTTOM;
                5'b0011_?: op_d = `OP_HALF_CVT_TOP;
                5'b0100_?: op_d = `OP_COMPARE;
                5'b0101_?: op_d = `OP_COMPARE_SIGNAL;
                5'b1000_?: op_d = `OP_CVT_INT;
                5'b110?_?: op_d = `OP_CVT_INT;
                5'b1?1?_?: op_d = `OP_CVT_FIXED;
                default:   op_d = `OP_NONE;
              endcase
            end
          end
          default: op_d = `OP_NONE;
        endcase
        if (op_d == `OP_NONE)
          undef_d = 1'b1;
      end
    end else if (ls_space) begin
      if (t_bit) begin
        undef_d = 1'b1;
      end else begin
        // transfers keep the width bit: doubleword moves are allowed
        dbl_d = width_select_bit;
        casez (ls_opcode)
          5'b0010?: begin
            class_d = `CLS_XFER64;
            op_d    = `OP_XFER64;
          end
          5'b01?00: begin
            class_d = `CLS_STORE;
            op_d    = `OP_STORE_MULTIPLE;
            mode_d  = `MODE_INC_AFTER;
          end
          5'b01?10: begin
            class_d = `CLS_STORE;
            op_d    = `OP_STORE_MULTIPLE;
            mode_d  = `MODE_INC_AFTER_WB;
          end
          5'b1??00: begin
            class_d = `CLS_STORE;
            op_d    = `OP_STORE_SINGLE;
            mode_d  = `MODE_OFFSET;
          end
          5'b10?10: begin
            class_d = `CLS_STORE;
            mode_d  = `MODE_DEC_BEFORE_WB;
            op_d    = (insn_word[19:16] == `STACK_REG) ? `OP_STACK_PUSH
                                                       : `OP_STORE_MULTIPLE;
          end
          5'b01?01: begin
            class_d = `CLS_LOAD;
            op_d    = `OP_LOAD_MULTIPLE;
            mode_d  = `MODE_INC_AFTER;
          end
          5'b01?11: begin
            class_d = `CLS_LOAD;
            mode_d  = `MODE_INC_AFTER_WB;
            op_d    = (insn_word[19:16] == `STACK_REG) ? `OP_STACK_POP
                                                       : `OP_LOAD_MULTIPLE;
          end
          5'b1??01: begin
            class_d = `CLS_LOAD;
            op_d    = `OP_LOAD_SINGLE;
            mode_d  = `MODE_OFFSET;
          end
          5'b10?11: begin
            class_d = `CLS_LOAD;
            op_d    = `OP_LOAD_MULTIPLE;
            mode_d  = `MODE_DEC_BEFORE_WB;
          end
          default: begin
            undef_d = 1'b1;
          end
        endcase
      end
    end else begin
      // anything outside both spaces is not ours to execute
      undef_d = 1'b1;
    end
  end

  // doubleword vs single register numbers
  wire [4:0] d_num  = dbl_d ? {d_bit, dest_reg_field}
                            : {dest_reg_field, d_bit};
  wire [4:0] n_num  = dbl_d ? {n_bit, first_src_reg_field}
                            : {first_src_reg_field, n_bit};
  wire [4:0] m_num  = dbl_d ? {m_bit, second_src_reg_field}
                            : {second_src_reg_field, m_bit};

  // outputs registered so downstream units see one stable decode per word
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dec_valid             <= 1'b0;
      dec_class             <= `CLS_NONE;
      dec_op                <= `OP_NONE;
      dec_mode              <= `MODE_NONE;
      dec_double            <= 1'b0;
      dest_reg              <= 5'h00;
      first_src_reg         <= 5'h00;
      second_src_reg        <= 5'h00;
      base_core_register    <= 4'h0;
      imm_offset            <= 8'h00;
      imm_value             <= 32'h0000_0000;
      coproc_num            <= 4'h0;
      coproc_data_operation <= 1'b0;
      coproc_load           <= 1'b0;
      coproc_store          <= 1'b0;
      undefined_insn        <= 1'b0;
    end else if (clk_en) begin
      dec_valid             <= insn_valid;
      dec_class             <= undef_d ? `CLS_NONE : class_d;
      dec_op                <= undef_d ? `OP_NONE : op_d;
      dec_mode              <= undef_d ? `MODE_NONE : mode_d;
      dec_double            <= dbl_d;
      dest_reg              <= d_num;
      first_src_reg         <= n_num;
      second_src_reg        <= m_num;
      base_core_register    <= insn_word[19:16];
      imm_offset            <= insn_word[7:0];
      imm_value             <= exp_imm;
      coproc_num            <= insn_word[8] ? `CP_FP_DOUBLE
                                            : `CP_FP_SINGLE;
      coproc_data_operation <= insn_valid && !undef_d &&
                               class_d == `CLS_DATA_OP;
      coproc_load           <= insn_valid && !undef_d &&
                               class_d == `CLS_LOAD;
      coproc_store          <= insn_valid && !undef_d &&
                               class_d == `CLS_STORE;
      undefined_insn        <= insn_valid && undef_d;
    end
  end
endmodule // fp_instruction_decoder

// >>> dv/fp_decoder_sva.sv
// concurrent checks on the decoder ports
`timescale 1ns/1ps
`include "fp_decoder_consts.vh"
module fp_decoder_sva (
  input wire        core_clk,
  input wire        reset,
  input wire        clk_en,
  input wire        insn_valid,
  input wire [31:0] insn_word,
  input wire [3:0]  dec_class,
  input wire [4:0]  dec_op,
  input wire [4:0]  dest_reg,
  input wire [31:0] imm_value,
  input wire [3:0]  coproc_num,
  input wire        coproc_data_operation,
  input wire        undefined_insn
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // t bit left free so both t values reach the antecedents
  sequence dp_take;
    clk_en && insn_valid && insn_word[31:29] == 3'b111 &&
    insn_word[27:24] == 4'he && insn_word[11:9] == 3'b101 && !insn_word[4];
  endsequence
  sequence ls_take;
    clk_en && insn_valid && insn_word[31:29] == 3'b111 &&
    insn_word[27:25] == 3'b110 && insn_word[11:9] == 3'b101;
  endsequence
  dp_t_undef_a: assert property (dp_take ##0 insn_word[28] |=> undefined_insn)
    else $error("data op with t set not undefined");
  dp_width_undef_a: assert property (dp_take ##0 insn_word[8] |=> undefined_insn)
    else $error("data op with width bit not undefined");
  ls_t_undef_a: assert property (ls_take ##0 insn_word[28] |=> undefined_insn)
    else $error("load store with t set not undefined");
  xfer_route_a: assert property (ls_take ##0 !insn_word[28] &&
    insn_word[24:21] == 4'b0010 |=> dec_class == `CLS_XFER64)
    else $error("0010x not routed to 64-bit transfer");
  imm_expand_a: assert property (clk_en |=> imm_value == {$past(insn_word[19]),
    ~$past(insn_word[18]), {5{$past(insn_word[18])}}, $past(insn_word[17:16]),
    $past(insn_word[3:0]), 19'h0})
    else $error("immediate expansion wrong");
  coproc_pick_a: assert property (ls_take ##0 !insn_word[28] |=>
    undefined_insn || coproc_num == ($past(insn_word[8]) ? 4'hb : 4'ha))
    else $error("coprocessor number wrong");
  dp_pattern_a: assert property (clk_en && insn_valid &&
    (insn_word[11:9] != 3'b101 || insn_word[4]) |=> !coproc_data_operation)
    else $error("data op outside fixed pattern");
  single_regs_a: assert property (ls_take ##0 !insn_word[8] |=> undefined_insn ||
    dest_reg == {$past(insn_word[15:12]), $past(insn_word[22])})
    else $error("single register number wrong");
  double_regs_a: assert property (ls_take ##0 insn_word[8] |=> undefined_insn ||
    dest_reg == {$past(insn_word[22]), $past(insn_word[15:12])})
    else $error("double register number wrong");
  undef_excl_a: assert property (undefined_insn |->
    dec_class == `CLS_NONE && dec_op == `OP_NONE)
    else $error("undefined word still classified");
endmodule // fp_decoder_sva
bind fp_instruction_decoder fp_decoder_sva chk (.core_clk(core_clk),
  .reset(reset), .clk_en(clk_en), .insn_valid(insn_valid),
  .insn_word(insn_word), .dec_class(dec_class), .dec_op(dec_op),
  .dest_reg(dest_reg), .imm_value(imm_value), .coproc_num(coproc_num),
  .coproc_data_operation(coproc_data_operation),
  .undefined_insn(undefined_insn));

// >>> dv/fetch_issue_model.sv
// fetch and issue stage model that presents instruction words
`timescale 1ns/1ps
module fetch_issue_model (
  input  wire        core_clk,
  output reg         insn_valid,
  output reg  [31:0] insn_word
);
  initial begin
    insn_valid = 1'b0;
    insn_word  = 32'h0000_0000;
  end
  // idle bus shows the inverse so a stale word cannot pass as valid data
  task issue(input [31:0] w);
    begin
      @(posedge core_clk) #1;
      insn_valid = 1'b1;
      insn_word  = w;
      @(posedge core_clk) #1;
      insn_valid = 1'b0;
      insn_word  = ~w;
    end
  endtask
endmodule // fetch_issue_model

// >>> dv/fp_instruction_decoder_tb.sv
// self-checking bench for the floating-point instruction decoder
`timescale 1ns/1ps
`include "fp_decoder_consts.vh"
module fp_instruction_decoder_tb;
  reg         core_clk, reset, clk_en;
  wire        insn_valid, dec_valid, dec_double, undefined_insn;
  wire        coproc_data_operation, coproc_load, coproc_store;
  wire [31:0] insn_word, imm_value;
  wire [3:0]  dec_class, base_core_register, coproc_num;
  wire [4:0]  dec_op, dest_reg, first_src_reg, second_src_reg;
  wire [2:0]  dec_mode;
  wire [7:0]  imm_offset;
  integer     n_fail = 0, total_checks = 0, cycles = 0;
  fetch_issue_model fetch (.core_clk(core_clk), .insn_valid(insn_valid),
    .insn_word(insn_word));
  fp_instruction_decoder dut (.core_clk(core_clk), .reset(reset),
    .clk_en(clk_en), .insn_valid(insn_valid), .insn_word(insn_word),
    .dec_valid(dec_valid), .dec_class(dec_class), .dec_op(dec_op),
    .dec_mode(dec_mode), .dec_double(dec_double), .dest_reg(dest_reg),
    .first_src_reg(first_src_reg), .second_src_reg(second_src_reg),
    .base_core_register(base_core_register), .imm_offset(imm_offset),
    .imm_value(imm_value), .coproc_num(coproc_num),
    .coproc_data_operation(coproc_data_operation), .coproc_load(coproc_load),
    .coproc_store(coproc_store), .undefined_insn(undefined_insn));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task report_and_stop;
    begin
      $display("checks %0d fails %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 1000) begin
      n_fail = n_fail + 1;
      report_and_stop;
    end
  end
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("Error %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // pulses are not judged on 64-bit transfers, which are only routed on
  task expect_dec(input [31:0] w, input [3:0] c, input [4:0] o,
                  input [2:0] m);
    begin
      fetch.issue(w);
      cmp({dec_valid, dec_class, dec_op}, {1'b1, c, o});
      if (c != `CLS_XFER64)
        cmp({undefined_insn, coproc_data_operation, coproc_load, coproc_store},
          {c == `CLS_NONE, c == `CLS_DATA_OP, c == `CLS_LOAD, c == `CLS_STORE});
      if (c == `CLS_LOAD || c == `CLS_STORE) cmp(dec_mode, m);
    end
  endtask
  task dp_test;
    begin
      expect_dec(32'hEE00_0A00, `CLS_DATA_OP, `OP_MUL_ACC, 3'h0);
      expect_dec(32'hEE00_0A40, `CLS_DATA_OP, `OP_MUL_SUB, 3'h0);
      expect_dec(32'hEE10_0A00, `CLS_DATA_OP, `OP_NEG_MUL_ACC, 3'h0);
      expect_dec(32'hEE10_0A40, `CLS_DATA_OP, `OP_NEG_MUL_SUB, 3'h0);
      expect_dec(32'hEE20_0A00, `CLS_DATA_OP, `OP_MULTIPLY, 3'h0);
      expect_dec(32'hEE20_0A40, `CLS_DATA_OP, `OP_NEG_MULTIPLY, 3'h0);
      expect_dec(32'hEE30_0A00, `CLS_DATA_OP, `OP_ADD, 3'h0);
      expect_dec(32'hEE30_0A40, `CLS_DATA_OP, `OP_SUBTRACT, 3'h0);
      expect_dec(32'hEE80_0A00, `CLS_DATA_OP, `OP_DIVIDE, 3'h0);
      expect_dec(32'hEEB0_0A40, `CLS_DATA_OP, `OP_MOVE_REG, 3'h0);
      expect_dec(32'hEEB0_0AC0, `CLS_DATA_OP, `OP_ABSOLUTE, 3'h0);
      expect_dec(32'hEEB1_0A40, `CLS_DATA_OP, `OP_NEGATE, 3'h0);
      expect_dec(32'hEEB1_0AC0, `CLS_DATA_OP, `OP_SQUARE_ROOT, 3'h0);
      expect_dec(32'hEEB2_0A40, `CLS_DATA_OP, `OP_HALF_CVT_BOTTOM, 3'h0);
      expect_dec(32'hEEB3_0A40, `CLS_DATA_OP, `OP_HALF_CVT_TOP, 3'h0);
      expect_dec(32'hEEB4_0A40, `CLS_DATA_OP, `OP_COMPARE, 3'h0);
      expect_dec(32'hEEB5_0A40, `CLS_DATA_OP, `OP_COMPARE_SIGNAL, 3'h0);
      expect_dec(32'hEEBC_0A40, `CLS_DATA_OP, `OP_CVT_INT, 3'h0);
      expect_dec(32'hEEB8_0A40, `CLS_DATA_OP, `OP_CVT_INT, 3'h0);
      expect_dec(32'hEEBA_0A40, `CLS_DATA_OP, `OP_CVT_FIXED, 3'h0);
      expect_dec(32'hFE30_0A00, `CLS_NONE, `OP_NONE, 3'h0);
      expect_dec(32'hEE30_0B00, `CLS_NONE, `OP_NONE, 3'h0);
      expect_dec(32'hEE30_0A10, `CLS_NONE, `OP_NONE, 3'h0);
      expect_dec(32'hEE80_0A40, `CLS_NONE, `OP_NONE, 3'h0);
      expect_dec(32'h0000_0000, `CLS_NONE, `OP_NONE, 3'h0);
    end
  endtask
  task ls_test;
    begin
      expect_dec(32'hEC83_0A02, `CLS_STORE, `OP_STORE_MULTIPLE, 3'h1);
      expect_dec(32'hECA3_0A02, `CLS_STORE, `OP_STORE_MULTIPLE, 3'h2);
      expect_dec(32'hED23_0A02, `CLS_STORE, `OP_STORE_MULTIPLE, 3'h3);
      expect_dec(32'hED2D_0A02, `CLS_STORE, `OP_STACK_PUSH, 3'h3);
      expect_dec(32'hEC93_0A02, `CLS_LOAD, `OP_LOAD_MULTIPLE, 3'h1);
      expect_dec(32'hECB3_0A02, `CLS_LOAD, `OP_LOAD_MULTIPLE, 3'h2);
      expect_dec(32'hECBD_0A02, `CLS_LOAD, `OP_STACK_POP, 3'h2);
      expect_dec(32'hED33_0A02, `CLS_LOAD, `OP_LOAD_MULTIPLE, 3'h3);
      expect_dec(32'hEC43_0A10, `CLS_XFER64, `OP_XFER64, 3'h0);
      expect_dec(32'hFDD3_5B08, `CLS_NONE, `OP_NONE, 3'h0);
    end
  endtask
  task reg_test;
    begin
      expect_dec(32'hEE75_AAA6, `CLS_DATA_OP, `OP_ADD, 3'h0);
      cmp({dest_reg, first_src_reg, second_src_reg}, 15'h556D);
      expect_dec(32'hEDD3_5B08, `CLS_LOAD, `OP_LOAD_SINGLE, `MODE_OFFSET);
      cmp({dec_double, dest_reg, coproc_num, base_core_register, imm_offset},
        {1'b1, 5'h15, 4'hb, 4'h3, 8'h08});
      cmp({first_src_reg, second_src_reg}, {5'h03, 5'h08});
      expect_dec(32'hED43_5A08, `CLS_STORE, `OP_STORE_SINGLE, `MODE_OFFSET);
      cmp({dec_double, dest_reg, coproc_num}, {1'b0, 5'h0b, 4'ha});
    end
  endtask
  task imm_test;
    begin
      expect_dec(32'hEEB7_0A00, `CLS_DATA_OP, `OP_MOVE_IMM, 3'h0);
      cmp(imm_value, 32'h3F80_0000);
      clk_en = 1'b0;
      fetch.issue(32'hEEBC_0A05);
      cmp({dec_valid, dec_op}, {1'b1, `OP_MOVE_IMM});
      cmp(imm_value, 32'h3F80_0000);
      clk_en = 1'b1;
      expect_dec(32'hEEBC_0A05, `CLS_DATA_OP, `OP_MOVE_IMM, 3'h0);
      cmp(imm_value, 32'hBE28_0000);
      @(posedge core_clk) #1;
      cmp({dec_valid, undefined_insn, coproc_data_operation}, 3'h0);
    end
  endtask
  initial begin
    reset  = 1'b1;
    clk_en = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 reset = 1'b0;
    cmp({dec_valid, dec_class, undefined_insn}, 6'h00);
    dp_test;
    ls_test;
    reg_test;
    imm_test;
    report_and_stop;
  end
endmodule // fp_instruction_decoder_tb
